// file: rtl/dpo_defs.svh
// constants of the dual pulse output generator
`ifndef DPO_DEFS_SVH
`define DPO_DEFS_SVH

// module clock rate in hertz
`define DPO_CLK_HZ        20000000
// counted pulse rates in hertz
`define DPO_HS_HZ         10000
`define DPO_LS_HZ         10
// highest frequency-mode output in hertz
`define DPO_FREQ_MAX_HZ   32000
// half-period counts of the counted pulse rates, in clock cycles
`define DPO_HS_HALF       (`DPO_CLK_HZ / (2 * `DPO_HS_HZ))
`define DPO_LS_HALF       (`DPO_CLK_HZ / (2 * `DPO_LS_HZ))
// control word values that select the counter flavour
`define DPO_ABS_LO        16'h0000
`define DPO_DIFF_LO       16'h0001
`define DPO_CTRL_HI       16'h0000
// count register pair that clears the previous absolute value
`define DPO_CLR_LO        16'h0000
`define DPO_CLR_HI        16'h8000
// widths
`define DPO_WORD_W        16
`define DPO_VAL_W         32
`define DPO_OWED_W        33
`define DPO_NCO_W         25
`define DPO_DIV_W         32

`endif

// file: rtl/dpo_pkg.sv
// types shared by the dual pulse output generator
`include "dpo_defs.svh"

package dpo_pkg;

    // gray along idle -> high -> low
    typedef enum logic [1:0] {
        ph_idle = 2'h0,
        ph_high = 2'h1,
        ph_low  = 2'h3
    } dpo_phase_e;

    typedef struct packed {
        dpo_phase_e                  phase;
        logic [`DPO_NCO_W-1:0]       acc;
        logic [`DPO_OWED_W-1:0]      owed;
        logic [`DPO_VAL_W-1:0]       prev;
        logic                        pulse;
    } dpo_chan_s;

    typedef struct packed {
        logic [`DPO_DIV_W-1:0]                 hs_div;
        logic [`DPO_DIV_W-1:0]                 ls_div;
        logic                                  tick_hs;
        logic                                  tick_ls;
        logic                                  halt;
        logic [1:0][`DPO_WORD_W-1:0]           ctrl_lo;
        logic [1:0][`DPO_WORD_W-1:0]           ctrl_hi;
        logic [1:0][`DPO_WORD_W-1:0]           cnt_lo;
        logic [1:0][`DPO_WORD_W-1:0]           freq_hz;
        logic [1:0]                            diff;
        logic [1:0]                            load;
        logic [1:0]                            clear;
        logic [1:0][`DPO_VAL_W-1:0]            load_val;
    } dpo_top_s;

endpackage

// file: rtl/dpo_chan_if.sv
// per-channel carrier between the controller side and one pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "dpo_defs.svh"

interface dpo_chan_if;
    logic                     freq_mode;
    logic                     speed_high;
    logic                     diff_mode;
    logic                     halt;
    logic                     tick_hs;
    logic                     tick_ls;
    logic                     load;
    logic                     clear;
    logic [`DPO_VAL_W-1:0]    load_val;
    logic [`DPO_WORD_W-1:0]   freq_hz;
    logic                     pulse;

    modport ctl (
        output freq_mode, speed_high, diff_mode, halt, tick_hs, tick_ls,
        output load, clear, load_val, freq_hz,
        input  pulse
    );
    modport gen (
        input  freq_mode, speed_high, diff_mode, halt, tick_hs, tick_ls,
        input  load, clear, load_val, freq_hz,
        output pulse
    );
endinterface

`default_nettype wire

// file: rtl/dpo_chan.sv
// one pulse generator channel: counted pulses or a square wave
`timescale 1ns/1ps
`default_nettype none
`include "dpo_defs.svh"

module dpo_chan (
    input  wire logic   core_clk,
    input  wire logic   rst_b,
    dpo_chan_if.gen     ch
);

    localparam logic [`DPO_NCO_W:0]  NCO_MOD  = (`DPO_NCO_W+1)'(`DPO_CLK_HZ);
    localparam logic [`DPO_OWED_W-1:0] OWED_MAX = '1;

    dpo_pkg::dpo_chan_s q;
    dpo_pkg::dpo_chan_s next_q;

    // saturate instead of wrapping so a flood of writes never shrinks the owed count; pulses past OWED_MAX are dropped
    function automatic logic [`DPO_OWED_W-1:0] sat_add(
        input logic [`DPO_OWED_W-1:0] a,
        input logic [`DPO_VAL_W-1:0]  b
    );
        logic [`DPO_OWED_W:0] s;
        s = {1'b0, a} + {2'b00, b};
        sat_add = s[`DPO_OWED_W] ? OWED_MAX : s[`DPO_OWED_W-1:0];
    endfunction

    always_comb
    begin
        logic                    tick;
        logic [`DPO_NCO_W:0]     sum;
        logic [`DPO_VAL_W-1:0]   add;
        next_q = q;
        tick   = ch.speed_high ? ch.tick_hs : ch.tick_ls;
        sum    = {1'b0, q.acc} + (`DPO_NCO_W+1)'({ch.freq_hz, 1'b0});
        add    = ch.diff_mode ? ch.load_val : ch.load_val - q.prev;
        if (ch.halt)
        begin
            next_q.phase = dpo_pkg::ph_idle;
            next_q.owed  = '0;
            next_q.acc   = '0;
            next_q.pulse = 1'b0;
        end
        else
        begin
            if (ch.freq_mode)
            begin
                // toggling at twice the rate keeps high and low time equal
                next_q.phase = dpo_pkg::ph_idle;
                if (ch.freq_hz == '0)
                begin
                    next_q.acc   = '0;
                    next_q.pulse = 1'b0;
                end
                else if (sum >= NCO_MOD)
                begin
                    next_q.acc   = `DPO_NCO_W'(sum - NCO_MOD);
                    next_q.pulse = ~q.pulse;
                end
                else
                begin
                    next_q.acc = `DPO_NCO_W'(sum);
                end
            end
            else
            begin
                unique case (q.phase)
                    dpo_pkg::ph_idle:
                    begin
                        next_q.pulse = 1'b0;
                        if (tick && q.owed != '0)
                        begin
                            next_q.phase = dpo_pkg::ph_high;
                            next_q.pulse = 1'b1;
                        end
                    end
                    dpo_pkg::ph_high:
                    begin
                        if (tick)
                        begin
                            next_q.phase = dpo_pkg::ph_low;
                            next_q.pulse = 1'b0;
                            next_q.owed  = q.owed - 1'b1;
                        end
                    end
                    dpo_pkg::ph_low:
                    begin
                        if (tick)
                        begin
                            if (q.owed != '0)
                            begin
                                next_q.phase = dpo_pkg::ph_high;
                                next_q.pulse = 1'b1;
                            end
                            else
                            begin
                                next_q.phase = dpo_pkg::ph_idle;
                            end
                        end
                    end
                    default:
                    begin
                        next_q.phase = dpo_pkg::ph_idle;
                        next_q.pulse = 1'b0;
                    end
                endcase
            end
            if (ch.load)
            begin
                next_q.owed = sat_add(next_q.owed, add);
                next_q.prev = ch.load_val;
            end
            if (ch.clear)
            begin
                next_q.prev = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    assign ch.pulse = q.pulse;

endmodule // dpo_chan

`default_nettype wire

// file: rtl/dpo_top.sv
// dual pulse output generator: write decode, rate dividers and two channels
//
// Overview of operation
// - in counter mode each channel emits exactly as many pulses as the written value asks for.
// - in frequency mode each channel runs a continuous square wave with equal high and low time.
// - the speed selection matters in counter mode only and is ignored in frequency mode.
// - high speed in counter mode sends the counted pulses at 10 kHz with 50% duty.
// - low speed in counter mode sends the counted pulses at 10 Hz with 50% duty.
// - on loss of power every output stops at 0 Hz and no further pulses are sent; a frequency-mode channel restarts its wave when power_ok returns.
// - each of the two channels has its own mode and speed selection.
// - in frequency mode the low word sets the frequency in hertz up to 32 kHz; high words are ignored.
// - in absolute mode the pulses sent are the new 32-bit value minus the previous one, wrapping.
// - both control words zero select absolute mode; low word 1 and high word 0 select differential.
// - a count written before the last one is finished is added to what is still owed.
`timescale 1ns/1ps
`default_nettype none
`include "dpo_defs.svh"

// write port:
//   wr_chan  channel of the word
//   wr_ctrl  1 control pair, 0 count pair (frequency word in frequency mode)
//   wr_high  1 high word, 0 low word
//   wr_data  the word; a count commits on its high word as {high, low}
// the pair low 0, high 8000 forgets the previous absolute value and sends nothing
// a high word alone commits with whatever low word was staged last

module dpo_top #(
    parameter int unsigned HS_HALF = `DPO_HS_HALF,
    parameter int unsigned LS_HALF = `DPO_LS_HALF
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    input  wire logic                      power_ok,
    input  wire logic [1:0]                freq_mode,
    input  wire logic [1:0]                speed_high,
    input  wire logic                      wr_valid,
    input  wire logic                      wr_chan,
    input  wire logic                      wr_ctrl,
    input  wire logic                      wr_high,
    input  wire logic [`DPO_WORD_W-1:0]    wr_data,
    output logic [1:0]                     pulse_out
);

    localparam logic [`DPO_DIV_W-1:0]  HS_LAST  = `DPO_DIV_W'(HS_HALF - 1);
    localparam logic [`DPO_DIV_W-1:0]  LS_LAST  = `DPO_DIV_W'(LS_HALF - 1);
    localparam logic [`DPO_WORD_W-1:0] FREQ_MAX = `DPO_WORD_W'(`DPO_FREQ_MAX_HZ);

    dpo_pkg::dpo_top_s q;
    dpo_pkg::dpo_top_s next_q;

    // end of a half period; >= rather than == so a count past last still wraps
    function automatic logic div_wrap(
        input logic [`DPO_DIV_W-1:0] cnt,
        input logic [`DPO_DIV_W-1:0] last
    );
        div_wrap = (cnt >= last);
    endfunction

    // one-step divider: returns the next count, wrapping after last
    function automatic logic [`DPO_DIV_W-1:0] div_step(
        input logic [`DPO_DIV_W-1:0] cnt,
        input logic [`DPO_DIV_W-1:0] last
    );
        div_step = div_wrap(cnt, last) ? '0 : cnt + `DPO_DIV_W'(1);
    endfunction

    // frequencies beyond the generator's reach are held at the ceiling
    function automatic logic [`DPO_WORD_W-1:0] clamp_freq(
        input logic [`DPO_WORD_W-1:0] f
    );
        clamp_freq = (f > FREQ_MAX) ? FREQ_MAX : f;
    endfunction

    // a zero low word staged and the sign-bit high word form the clear pair
    function automatic logic is_clear_pair(
        input logic [`DPO_WORD_W-1:0] hi,
        input logic [`DPO_WORD_W-1:0] lo
    );
        is_clear_pair = (hi == `DPO_CLR_HI) && (lo == `DPO_CLR_LO);
    endfunction

    // differential flag from a control pair; other pairs keep the old flavour
    function automatic logic ctrl_flavour(
        input logic [`DPO_WORD_W-1:0] lo,
        input logic [`DPO_WORD_W-1:0] hi,
        input logic                   cur
    );
        ctrl_flavour = cur;
        if (hi == `DPO_CTRL_HI)
        begin
            if (lo == `DPO_ABS_LO)
            begin
                ctrl_flavour = 1'h0;
            end
            else if (lo == `DPO_DIFF_LO)
            begin
                ctrl_flavour = 1'h1;
            end
        end
    endfunction

    always_comb
    begin
        logic c;
        next_q = q;
        c      = wr_chan;

        // shared enables: both channels step on the same half-period grid,
        // so the first counted pulse may wait up to one half period
        next_q.hs_div  = div_step(q.hs_div, HS_LAST);
        next_q.ls_div  = div_step(q.ls_div, LS_LAST);
        next_q.tick_hs = div_wrap(q.hs_div, HS_LAST);
        next_q.tick_ls = div_wrap(q.ls_div, LS_LAST);

        next_q.halt  = ~power_ok;
        next_q.load  = 2'h0;
        next_q.clear = 2'h0;

        // writes made while power is lost are dropped; the channels are halted
        if (wr_valid && power_ok)
        begin
            if (wr_ctrl)
            begin
                if (wr_high)
                begin
                    next_q.ctrl_hi[c] = wr_data;
                end
                else
                begin
                    next_q.ctrl_lo[c] = wr_data;
                end
            end
            else if (freq_mode[c])
            begin
                // high word has no meaning at these rates and is dropped
                if (!wr_high)
                begin
                    next_q.freq_hz[c] = clamp_freq(wr_data);
                end
            end
            else if (!wr_high)
            begin
                next_q.cnt_lo[c] = wr_data;
            end
            else if (is_clear_pair(wr_data, q.cnt_lo[c]))
            begin
                next_q.clear[c] = 1'b1;
            end
            else
            begin
                // the high word completes the 32-bit value and commits it
                next_q.load[c]     = 1'b1;
                next_q.load_val[c] = {wr_data, q.cnt_lo[c]};
            end
        end

        // the flavour follows the control pair as soon as a word of it lands
        for (int i = 0; i < 2; i++)
        begin
            next_q.diff[i] = ctrl_flavour(next_q.ctrl_lo[i], next_q.ctrl_hi[i], q.diff[i]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    dpo_chan_if ch_if [2] ();

    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        assign ch_if[g].freq_mode  = freq_mode[g];
        assign ch_if[g].speed_high = speed_high[g];
        assign ch_if[g].diff_mode  = q.diff[g];
        assign ch_if[g].halt       = q.halt;
        assign ch_if[g].tick_hs    = q.tick_hs;
        assign ch_if[g].tick_ls    = q.tick_ls;
        assign ch_if[g].load       = q.load[g];
        assign ch_if[g].clear      = q.clear[g];
        assign ch_if[g].load_val   = q.load_val[g];
        assign ch_if[g].freq_hz    = q.freq_hz[g];

        dpo_chan dpo_chan_i (
            .core_clk (core_clk),
            .rst_b    (rst_b),
            .ch       (ch_if[g])
        );

        // driven straight from the channel's output flop
        assign pulse_out[g] = ch_if[g].pulse;
    end

endmodule // dpo_top

`default_nettype wire

// file: testbench/dpo_top_assertions.sv
// concurrent checks on the pins of the dual pulse output generator
`timescale 1ns/1ps
`default_nettype none
`include "dpo_defs.svh"
module dpo_top_assertions #(
    parameter int unsigned HS_HALF = `DPO_HS_HALF,
    parameter int unsigned LS_HALF = `DPO_LS_HALF
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        power_ok,
    input  wire logic [1:0]  freq_mode,
    input  wire logic [1:0]  speed_high,
    input  wire logic        wr_valid,
    input  wire logic        wr_chan,
    input  wire logic        wr_ctrl,
    input  wire logic        wr_high,
    input  wire logic [15:0] wr_data,
    input  wire logic [1:0]  pulse_out
);
    int unsigned hi [2];
    int unsigned lo [2];
    int unsigned lo_prev [2];
    int unsigned quiet [2];

    // run lengths per level; quiet counts freq-mode cycles since the last write
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hi      <= '{0, 0};
            lo      <= '{0, 0};
            lo_prev <= '{0, 0};
            quiet   <= '{0, 0};
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                hi[c] <= pulse_out[c] ? hi[c] + 1 : 0;
                lo[c] <= pulse_out[c] ? 0 : lo[c] + 1;
                if (pulse_out[c] && hi[c] == 0)
                    lo_prev[c] <= lo[c];
                quiet[c] <= (!freq_mode[c] || (wr_valid && wr_chan == c[0])) ? 0 : quiet[c] + 1;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_power_stop;
        !power_ok |-> ##2 pulse_out == 2'b00;
    endproperty
    a_power_stop: assert property (p_power_stop) else $error("pulse after power loss");

    property p_reset_quiet;
        $rose(rst_b) |-> (pulse_out == 2'b00) [*3];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("pulse right after reset");

    // power_ok guard: a pulse cut short by power loss is legal
    property p_hs_hi0;
        !pulse_out[0] && hi[0] != 0 && !freq_mode[0] && speed_high[0] && power_ok
            |-> hi[0] == HS_HALF;
    endproperty
    a_hs_hi0: assert property (p_hs_hi0) else $error("fast high time wrong ch0");

    property p_hs_hi1;
        !pulse_out[1] && hi[1] != 0 && !freq_mode[1] && speed_high[1] && power_ok
            |-> hi[1] == HS_HALF;
    endproperty
    a_hs_hi1: assert property (p_hs_hi1) else $error("fast high time wrong ch1");

    property p_ls_hi0;
        !pulse_out[0] && hi[0] != 0 && !freq_mode[0] && !speed_high[0] && power_ok
            |-> hi[0] == LS_HALF;
    endproperty
    a_ls_hi0: assert property (p_ls_hi0) else $error("slow high time wrong ch0");

    property p_ls_hi1;
        !pulse_out[1] && hi[1] != 0 && !freq_mode[1] && !speed_high[1] && power_ok
            |-> hi[1] == LS_HALF;
    endproperty
    a_ls_hi1: assert property (p_ls_hi1) else $error("slow high time wrong ch1");

    property p_duty0;
        !pulse_out[0] && hi[0] != 0 && freq_mode[0] && quiet[0] > lo_prev[0] + hi[0] + 2
            |-> hi[0] <= lo_prev[0] + 1 && lo_prev[0] <= hi[0] + 1;
    endproperty
    a_duty0: assert property (p_duty0) else $error("square wave uneven ch0");

    property p_duty1;
        !pulse_out[1] && hi[1] != 0 && freq_mode[1] && quiet[1] > lo_prev[1] + hi[1] + 2
            |-> hi[1] <= lo_prev[1] + 1 && lo_prev[1] <= hi[1] + 1;
    endproperty
    a_duty1: assert property (p_duty1) else $error("square wave uneven ch1");

    c_fast: cover property (!freq_mode[0] && speed_high[0] && $rose(pulse_out[0]));
    c_slow: cover property (!freq_mode[1] && !speed_high[1] && $rose(pulse_out[1]));
    c_freq: cover property (freq_mode[1] && $rose(pulse_out[1]));
    c_loss: cover property ($fell(power_ok));
endmodule // dpo_top_assertions

bind dpo_top dpo_top_assertions #(.HS_HALF(HS_HALF), .LS_HALF(LS_HALF)) dpo_top_assertions_i (
    .core_clk(core_clk), .rst_b(rst_b), .power_ok(power_ok), .freq_mode(freq_mode),
    .speed_high(speed_high), .wr_valid(wr_valid), .wr_chan(wr_chan), .wr_ctrl(wr_ctrl),
    .wr_high(wr_high), .wr_data(wr_data), .pulse_out(pulse_out));
`default_nettype wire

// file: testbench/dpo_pulse_sink.sv
// pulse counting input device that listens to both outputs
`timescale 1ns/1ps
`default_nettype none
module dpo_pulse_sink (
    input  wire logic       core_clk,
    input  wire logic [1:0] pulse_out,
    output int unsigned     rises [2],
    output int unsigned     hi_len [2],
    output int unsigned     lo_len [2]
);
    int unsigned run [2] = '{0, 0};
    logic [1:0]  lvl = 2'b00;

    initial
    begin
        rises = '{0, 0};
        hi_len = '{0, 0};
        lo_len = '{0, 0};
    end

    // an electronic counter: counts rises, keeps the last high and low widths
    always @(posedge core_clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (pulse_out[c] !== lvl[c])
            begin
                if (pulse_out[c] === 1'b1)
                begin
                    rises[c]  <= rises[c] + 1;
                    lo_len[c] <= run[c];
                end
                else
                begin
                    hi_len[c] <= run[c];
                end
                run[c] <= 1;
            end
            else
            begin
                run[c] <= run[c] + 1;
            end
        end
        lvl <= pulse_out;
    end
endmodule // dpo_pulse_sink
`default_nettype wire

// file: testbench/dpo_top_tb_top.sv
// self-checking bench for the dual pulse output generator
`timescale 1ns/1ps
`default_nettype none
module dpo_top_tb_top;
    localparam int unsigned HS = 4;
    localparam int unsigned LS = 10;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        power_ok = 1'b1;
    logic [1:0]  freq_mode = 2'b00;
    logic [1:0]  speed_high = 2'b11;
    logic        wr_valid = 1'b0;
    logic        wr_chan = 1'b0;
    logic        wr_ctrl = 1'b0;
    logic        wr_high = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic [1:0]  pulse_out;
    int unsigned rises [2];
    int unsigned hi_len [2];
    int unsigned lo_len [2];
    int unsigned base [2];
    int          error_cnt = 0;
    int          n_tests = 0;
    logic [31:0] seed = 32'h8c989163;
    logic [31:0] f0;

    always #25 core_clk = ~core_clk;

    dpo_top #(.HS_HALF(HS), .LS_HALF(LS)) dpo_top_i (
        .core_clk(core_clk), .rst_b(rst_b), .power_ok(power_ok), .freq_mode(freq_mode),
        .speed_high(speed_high), .wr_valid(wr_valid), .wr_chan(wr_chan), .wr_ctrl(wr_ctrl),
        .wr_high(wr_high), .wr_data(wr_data), .pulse_out(pulse_out));
    dpo_pulse_sink dpo_pulse_sink_i (.core_clk(core_clk), .pulse_out(pulse_out),
        .rises(rises), .hi_len(hi_len), .lo_len(lo_len));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic near(input logic [31:0] a, input logic [31:0] b);
        return a + 1 >= b && a <= b + 1;
    endfunction

    // absolute mode sends the step from the previous value, modulo 2^32
    function automatic logic [31:0] abs_owed(input logic [31:0] nv, input logic [31:0] pv);
        return nv - pv;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic ch, input logic ctl, input logic hw, input logic [15:0] d);
        @(negedge core_clk);
        {wr_valid, wr_chan, wr_ctrl, wr_high, wr_data} = {1'b1, ch, ctl, hw, d};
        @(negedge core_clk);
        wr_valid = 1'b0;
    endtask

    // a count commits on its high word, so low goes first
    task automatic put(input logic ch, input logic [31:0] v);
        wr(ch, 1'b0, 1'b0, v[15:0]);
        wr(ch, 1'b0, 1'b1, v[31:16]);
    endtask

    task automatic wait_pulses(input int unsigned n, input int unsigned h);
        repeat ((2 * n + 4) * h + 8) @(negedge core_clk);
    endtask

    task automatic got(input logic [31:0] e0, input logic [31:0] e1);
        check(rises[0] - base[0], e0);
        check(rises[1] - base[1], e1);
        base = rises;
    endtask

    // the scenarios take about 21,000 cycles; a hang lands here
    initial
    begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        repeat (8) @(negedge core_clk);
        rst_b = 1'b1;
        check(pulse_out, 2'b00);
        wr(1'b1, 1'b1, 1'b0, 16'h0001);
        wr(1'b1, 1'b1, 1'b1, 16'h0000);
        wr(1'b0, 1'b1, 1'b0, 16'h0000);
        wr(1'b0, 1'b1, 1'b1, 16'h0000);
        base = rises;
        put(1'b0, 32'h0000_0005);
        put(1'b1, 32'h0000_0003);
        put(1'b1, 32'h0000_0002);
        wait_pulses(5, HS);
        got(5, 5);
        check(hi_len[0], HS);
        check(lo_len[0], HS);
        check(pulse_out, 2'b00);
        put(1'b0, 32'h0000_0008);
        wait_pulses(3, HS);
        got(abs_owed(32'h8, 32'h5), 0);
        speed_high = 2'b00;
        seed = lfsr(seed);
        put(1'b0, 32'h0000_000a);
        put(1'b1, {29'h0, seed[2:0]} + 2);
        wait_pulses(10, LS);
        got(abs_owed(32'ha, 32'h8), {29'h0, seed[2:0]} + 2);
        check(hi_len[1], LS);
        check(lo_len[1], LS);
        speed_high = 2'b11;
        put(1'b0, 32'h8000_0000);
        put(1'b0, 32'h0000_0003);
        wait_pulses(3, HS);
        got(abs_owed(32'h3, 32'h0), 0);
        // new value below previous wraps through zero: a huge run starts
        put(1'b0, 32'h0000_0001);
        wait_pulses(4, HS);
        check(rises[0] - base[0] >= 3, 1'b1);
        power_ok = 1'b0;
        repeat (3) @(negedge core_clk);
        check(pulse_out, 2'b00);
        base = rises;
        wait_pulses(8, HS);
        got(0, 0);
        power_ok = 1'b1;
        wait_pulses(8, HS);
        got(0, 0);
        freq_mode = 2'b11;
        seed = lfsr(seed);
        // one channel at each speed, so a setting that leaked in would show
        speed_high = {seed[1], ~seed[1]};
        f0 = 1000 + seed % 31001;
        wr(1'b0, 1'b0, 1'b0, f0[15:0]);
        wr(1'b0, 1'b0, 1'b1, 16'hffff);
        wr(1'b1, 1'b0, 1'b0, 16'h9c40);
        repeat (400) @(negedge core_clk);
        base = rises;
        repeat (20000) @(negedge core_clk);
        check(near(rises[0] - base[0], f0 / 1000), 1'b1);
        check(near(rises[1] - base[1], 32), 1'b1);
        check(near(hi_len[1], lo_len[1]), 1'b1);
        check(near(hi_len[0], lo_len[0]), 1'b1);
        give_verdict();
    end
endmodule // dpo_top_tb_top
`default_nettype wire
